// file: dv/osc_analog_regs_checker.sv
// Purpose : Port assertions for the oscillator register bank.
// Assumes : Zero-wait APB slave, writes land at the pready edge.
// Notes   : Bound to the design from tb_top.
`timescale 1ns/1ps
`default_nettype none
module osc_analog_regs_checker
    import osc_analog_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input wire logic              pclk,
    input wire logic              presetn,
    // APB
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [3:0]        pstrb,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // Analog side
    input wire logic [15:0]       ana_status_raw,
    input wire logic              slow_crystal_osc_en,
    input wire fast_clk_t         fast_clk_ctrl,
    input wire lowfreq_rc_t       lowfreq_rc_ctrl,
    input wire ref_trim_t         ref_trim_ctrl,
    input wire logic              usb_supply_irq
);
    // ************************************************************
    // Write decodes and assertions
    // ************************************************************
    logic wr;
    logic ws;
    logic wf;
    logic wl;
    logic wt;
    logic wc;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Writes strobing both low byte lanes, per register
    assign wr = psel && penable && pwrite && pready && (pstrb[1:0] == 2'b11);
    assign ws = wr && (paddr == ADDR_W'(12'h080));
    assign wf = wr && (paddr == ADDR_W'(12'h088));
    assign wl = wr && (paddr == ADDR_W'(12'h090));
    assign wt = wr && (paddr == ADDR_W'(12'h0A0));
    assign wc = wr && (paddr == ADDR_W'(12'h0C8));
    property p_slow; ws |=> slow_crystal_osc_en == $past(pwdata[0]);
    endproperty
    a_slow: assert property (p_slow) else $error("slow enable");
    property p_rc_en; wf |=> fast_clk_ctrl.fast_rc_osc_en == $past(pwdata[0]);
    endproperty
    a_rc_en: assert property (p_rc_en) else $error("rc enable");
    property p_filt; wf |=> {fast_clk_ctrl.crystal_highpass_en,
        fast_clk_ctrl.crystal_spike_filter_bypass} == $past(pwdata[14:13]);
    endproperty
    a_filt: assert property (p_filt) else $error("filter bits");
    property p_amp_cur; wf |=> {fast_clk_ctrl.crystal_amplitude_trim,
        fast_clk_ctrl.crystal_startup_current}
        == {$past(pwdata[12:10]), $past(pwdata[7:5])};
    endproperty
    a_amp_cur: assert property (p_amp_cur) else $error("trims");
    property p_lowf; wl |=> lowfreq_rc_ctrl == $past(pwdata[11:0]); endproperty
    a_lowf: assert property (p_lowf) else $error("lowfreq rc");
    property p_ref; wt |=> ref_trim_ctrl == $past(pwdata[14:0]); endproperty
    a_ref: assert property (p_ref) else $error("reference trims");
    property p_rst; $rose(presetn) |->
        fast_clk_ctrl == 13'h15A0 && lowfreq_rc_ctrl == 12'h04C2;
    endproperty
    a_rst: assert property (p_rst) else $error("reset fields");
    property p_clr;
        ($stable(ana_status_raw[12]) [*7]) ##0 wc |=> !usb_supply_irq;
    endproperty
    a_clr: assert property (p_clr) else $error("irq not cleared");
    // Main scenarios
    c_irq: cover property ($rose(usb_supply_irq));
    c_err: cover property (pready && pslverr);
    c_stat: cover property (pready && !pwrite && prdata[3] && prdata[2]);
endmodule
`default_nettype wire

// file: dv/tb_top.sv
// Purpose : Self-checking bench for the oscillator register bank.
// Assumes : Zero-wait APB slave, byte address is index times four.
// Notes   : Bench drives the analog status levels directly.
`timescale 1ns/1ps
`default_nettype none
module tb_top import osc_analog_pkg::*; ();
    // ************************************************************
    // Signals, tasks and main sequence
    // ************************************************************
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0]  pstrb = 4'hF;
    logic [3:0]  stb = 4'hF;
    logic [15:0] ana_status_raw = 16'h0090;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, se, slow_crystal_osc_en, usb_supply_irq;
    fast_clk_t   fast_clk_ctrl;
    lowfreq_rc_t lowfreq_rc_ctrl;
    ref_trim_t   ref_trim_ctrl;
    int          err_total = 0;
    int          compares = 0;
    int          cycles = 0;
    logic [11:0] ra [5] = '{12'h080, 12'h088, 12'h090, 12'h0A0, 12'h0C0};
    logic [15:0] rv [5] = '{16'h0000, 16'h54A0, 16'h04C2, 16'h0000, 16'h0000};
    logic [15:0] wm [5] = '{16'h0001, 16'h7CFF, 16'h0FFF, 16'h7FFF, 16'h0003};
    // Device under test
    osc_analog_regs #(.ADDR_W(12)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ana_status_raw(ana_status_raw),
        .slow_crystal_osc_en(slow_crystal_osc_en),
        .fast_clk_ctrl(fast_clk_ctrl), .lowfreq_rc_ctrl(lowfreq_rc_ctrl),
        .ref_trim_ctrl(ref_trim_ctrl), .usb_supply_irq(usb_supply_irq));
    // 100 MHz clock
    initial forever #5 pclk = ~pclk;
    // Hang guard
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            end_sim();
        end
    end
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One APB transfer, answer taken at the pready edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= stb;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // Write, read back, compare
    task automatic wrd(input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] exp);
        apb(1'b1, a, d);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask
    // Optional clear, set enable, move comparator, judge the line
    task automatic irq_step(input logic clr, input logic [15:0] en,
                            input logic lvl, input logic exp);
        if (clr) apb(1'b1, 12'h0C8, 32'h0000_A5C3);
        apb(1'b1, 12'h0C0, {16'h0, en});
        ana_status_raw[12] <= lvl;
        repeat (8) @(posedge pclk);
        @(negedge pclk);
        check({31'h0, usb_supply_irq}, {31'h0, exp});
    endtask
    // Reset values of every readable register except the interrupt status
    task automatic t_reset();
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, ra[i], 32'h0);
            check(rd, {16'h0, rv[i]});
        end
        apb(1'b0, 12'h0A8, 32'h0);
        check(rd, 32'h0000_0090);
        check({19'h0, fast_clk_ctrl}, 32'h0000_15A0);
    endtask
    // Writable bits only, byte lanes
    task automatic t_mask();
        for (int i = 0; i < 5; i++) wrd(ra[i], 32'hFFFF_FFFF, {16'h0, wm[i]});
        check({19'h0, fast_clk_ctrl}, 32'h0000_1FFF);
        check({20'h0, lowfreq_rc_ctrl}, 32'h0000_0FFF);
        check({31'h0, slow_crystal_osc_en}, 32'h1);
        check({17'h0, ref_trim_ctrl}, 32'h0000_7FFF);
        for (int i = 0; i < 5; i++) wrd(ra[i], 32'h0, 32'h0);
        stb = 4'h1;
        wrd(12'h088, 32'hFFFF_FFFF, 32'h0000_00FF);
        stb = 4'hF;
        wrd(12'h0A0, 32'h0000_4000, 32'h0000_4000);
    endtask
    // Status word follows levels and ignores writes
    task automatic t_status();
        ana_status_raw <= 16'h009C;
        repeat (6) @(posedge pclk);
        apb(1'b1, 12'h0A8, 32'hFFFF_FFFF);
        check({31'h0, se}, 32'h0);
        wrd(12'h0A8, 32'h0, 32'h0000_009C);
        ana_status_raw <= 16'h0090;
        repeat (6) @(posedge pclk);
        wrd(12'h0A8, 32'hFFFF_FFFF, 32'h0000_0090);
    endtask
    // Supply interrupt: raise, mask, clear
    task automatic t_irq();
        irq_step(1'b0, 16'h0002, 1'b1, 1'b1);
        irq_step(1'b1, 16'h0002, 1'b1, 1'b0);
        irq_step(1'b0, 16'h0001, 1'b0, 1'b1);
        irq_step(1'b1, 16'h0000, 1'b1, 1'b0);
        irq_step(1'b0, 16'h0002, 1'b1, 1'b1);
        irq_step(1'b1, 16'h0000, 1'b0, 1'b0);
        apb(1'b0, 12'h0B8, 32'h0);
        check(rd, 32'h0000_0001);
        wrd(12'h0B8, 32'h0000_0003, 32'h0);
    endtask
    // Unmapped place and write-only clear
    task automatic t_unmapped();
        apb(1'b1, 12'h0FC, 32'hFFFF_FFFF);
        check({31'h0, se}, 32'h1);
        apb(1'b0, 12'h0FC, 32'h0);
        check({31'h0, se}, 32'h1);
        wrd(12'h0C8, 32'hFFFF_FFFF, 32'h0);
    endtask
    // Verdict and stop
    task automatic end_sim();
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Main sequence with a second reset mid-run
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_mask();
        t_status();
        t_irq();
        t_unmapped();
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        end_sim();
    end
endmodule
bind osc_analog_regs osc_analog_regs_checker #(.ADDR_W(ADDR_W)) chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ana_status_raw(ana_status_raw),
    .slow_crystal_osc_en(slow_crystal_osc_en),
    .fast_clk_ctrl(fast_clk_ctrl), .lowfreq_rc_ctrl(lowfreq_rc_ctrl),
    .ref_trim_ctrl(ref_trim_ctrl), .usb_supply_irq(usb_supply_irq));
`default_nettype wire

// file: src/level_sync.sv
// Purpose : Three-stage synchroniser with agreement filter for levels.
// Assumes : Inputs are asynchronous to pclk.
// Notes   : A bit changes only once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
    parameter int          WIDTH     = 16,
    parameter logic [15:0] RESET_VAL = 16'h0000
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Levels
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;

    // Shift chain; stage one feeds stage two only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1_reg <= RESET_VAL[WIDTH-1:0];
            stage2_reg <= RESET_VAL[WIDTH-1:0];
            stage3_reg <= RESET_VAL[WIDTH-1:0];
        end else begin
            stage1_reg <= async_in;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // Per bit: follow when two and three agree, else hold
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_out <= RESET_VAL[WIDTH-1:0];
        end else begin
            sync_out <= (stage2_reg & stage3_reg)
                      | (sync_out & (stage2_reg | stage3_reg));
        end
    end

endmodule
`default_nettype wire

// file: src/osc_analog_pkg.sv
// Purpose : Shared constants and carriers for the oscillator and analog
//           supply control register bank.
// Assumes : 16-bit registers on a 32-bit APB data bus, one word each.
// Notes   : Register offsets are word indices; byte address is index * 4.
package osc_analog_pkg;

    // ********************************************************************
    // Register word indices (byte address is four times the index)
    // ********************************************************************
    localparam logic [31:0] SLOW_XTAL_IDX  = 32'h5000_0020;
    localparam logic [31:0] FAST_CLK_IDX   = 32'h5000_0022;
    localparam logic [31:0] LOWF_RC_IDX    = 32'h5000_0024;
    localparam logic [31:0] REF_TRIM_IDX   = 32'h5000_0028;
    localparam logic [31:0] ANA_STAT_IDX   = 32'h5000_002A;
    localparam logic [31:0] IRQ_STAT_IDX   = 32'h5000_002E;
    localparam logic [31:0] IRQ_EN_IDX     = 32'h5000_0030;
    localparam logic [31:0] IRQ_CLR_IDX    = 32'h5000_0032;

    // ********************************************************************
    // Reset values and writable bit masks
    // ********************************************************************
    localparam logic [15:0] SLOW_XTAL_RST  = 16'h0000;
    localparam logic [15:0] SLOW_XTAL_WMSK = 16'h0001;
    localparam logic [15:0] FAST_CLK_RST   = 16'h54A0;
    localparam logic [15:0] FAST_CLK_WMSK  = 16'h7CFF;
    localparam logic [15:0] LOWF_RC_RST    = 16'h04C2;
    localparam logic [15:0] LOWF_RC_WMSK   = 16'h0FFF;
    localparam logic [15:0] REF_TRIM_RST   = 16'h0000;
    localparam logic [15:0] REF_TRIM_WMSK  = 16'h7FFF;
    localparam logic [15:0] ANA_STAT_RST   = 16'h0090;
    localparam logic [1:0]  IRQ_RST        = 2'h0;

    // ********************************************************************
    // Field positions
    // ********************************************************************
    localparam int IRQ_FALL_BIT  = 0;
    localparam int IRQ_RISE_BIT  = 1;
    localparam int VBUS_CMP_BIT  = 12;
    localparam int NEW_BAT_BIT   = 3;
    localparam int VBUS_AVL_BIT  = 2;

    // ********************************************************************
    // Carriers towards the analog blocks
    // ********************************************************************
    typedef struct packed {
        logic       crystal_highpass_en;
        logic       crystal_spike_filter_bypass;
        logic [2:0] crystal_amplitude_trim;
        logic [2:0] crystal_startup_current;
        logic [3:0] fast_rc_osc_trim;
        logic       fast_rc_osc_en;
    } fast_clk_t;

    typedef struct packed {
        logic       lowfreq_rc_en;
        logic       lowfreq_rc_extra_low;
        logic [1:0] lowfreq_rc_bias;
        logic [3:0] lowfreq_rc_temp_ctrl;
        logic [3:0] lowfreq_rc_trim;
    } lowfreq_rc_t;

    typedef struct packed {
        logic       supply_reg_ref_select;
        logic [3:0] sleep_reg_trim;
        logic [4:0] reference_bias_trim;
        logic [4:0] reference_voltage_trim;
    } ref_trim_t;

endpackage

// file: src/osc_analog_regs.sv
// Purpose : APB register bank for oscillator and analog supply control.
// Assumes : APB4 slave, zero wait states, 16-bit registers in low lanes.
// Notes   : Status word inputs are synchronised; supply events raise irq.
//           Write-only and unmapped words read back as zero.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module osc_analog_regs
    import osc_analog_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output var  logic [31:0]       prdata,
    output var  logic              pready,
    output var  logic              pslverr,
    // Analog status levels from comparators and detectors
    input  wire logic [15:0]       ana_status_raw,
    // Oscillator and reference controls
    output var  logic              slow_crystal_osc_en,
    output var  fast_clk_t         fast_clk_ctrl,
    output var  lowfreq_rc_t       lowfreq_rc_ctrl,
    output var  ref_trim_t         ref_trim_ctrl,
    // Interrupt
    output var  logic              usb_supply_irq
);

    // ********************************************************************
    // Declarations
    // ********************************************************************
    logic [15:0] slow_xtal_reg;
    logic [15:0] fast_clk_reg;
    logic [15:0] lowf_rc_reg;
    logic [15:0] ref_trim_reg;
    logic [1:0]  irq_en_reg;
    logic [1:0]  irq_stat_reg;
    logic [1:0]  irq_stat_next;
    logic        vbus_prev_reg;
    logic [15:0] ana_status_sync;
    logic [15:0] wr_bits;
    logic [15:0] rd_next;
    logic        hit_any;
    logic        setup_phase;
    logic        wr_en;
    logic        sel_slow;
    logic        sel_fast;
    logic        sel_lowf;
    logic        sel_ref;
    logic        sel_stat;
    logic        sel_istat;
    logic        sel_ien;
    logic        sel_iclr;
    logic        vbus_rise;
    logic        vbus_fall;

    // ********************************************************************
    // Address decode
    // ********************************************************************

    // Word index compare on the address bits above the byte lanes
    // Bits above ADDR_W are not decoded, so the bank repeats in memory
    function automatic logic idx_hit(input logic [ADDR_W-1:0] addr,
                                     input logic [31:0]       idx);
        logic [31:0] byte_addr;
        byte_addr = {idx[29:0], 2'b00};
        return addr[ADDR_W-1:2] == byte_addr[ADDR_W-1:2];
    endfunction

    // Merge written lanes into a register under its writable mask
    // Reserved bits are forced to reset, so written data never sticks
    function automatic logic [15:0] merge(input logic [15:0] cur,
                                          input logic [15:0] wmsk,
                                          input logic [15:0] rst,
                                          input logic [15:0] wd);
        logic [15:0] upd;
        upd = (cur & ~wmsk) | (wd & wmsk);
        return (upd & wmsk) | (rst & ~wmsk);
    endfunction

    // Register selects
    // Each select compares one word index; byte lanes are ignored
    assign sel_slow  = idx_hit(paddr, SLOW_XTAL_IDX);
    assign sel_fast  = idx_hit(paddr, FAST_CLK_IDX);
    assign sel_lowf  = idx_hit(paddr, LOWF_RC_IDX);
    assign sel_ref   = idx_hit(paddr, REF_TRIM_IDX);
    assign sel_stat  = idx_hit(paddr, ANA_STAT_IDX);
    assign sel_istat = idx_hit(paddr, IRQ_STAT_IDX);
    assign sel_ien   = idx_hit(paddr, IRQ_EN_IDX);
    assign sel_iclr  = idx_hit(paddr, IRQ_CLR_IDX);
    // Any miss answers with an error and leaves every register alone
    assign hit_any   = sel_slow | sel_fast | sel_lowf | sel_ref | sel_stat
                     | sel_istat | sel_ien | sel_iclr;

    // Phases; a write lands in the access cycle with pready high
    // A setup cycle alone never alters state, so an aborted access is safe
    assign setup_phase = psel & ~penable;
    assign wr_en       = psel & penable & pready & pwrite;

    // Byte lanes: unstrobed lanes keep the current contents
    function automatic logic [15:0] lanes(input logic [15:0] cur,
                                          input logic [15:0] wd,
                                          input logic [1:0]  strb);
        logic [15:0] res;
        res[7:0]  = strb[0] ? wd[7:0]  : cur[7:0];
        res[15:8] = strb[1] ? wd[15:8] : cur[15:8];
        return res;
    endfunction

    // Only the low half of the data bus reaches the registers
    assign wr_bits = pwdata[15:0];

    // ********************************************************************
    // APB answer
    // ********************************************************************

    // Read data mux; write-only and unmapped words read zero
    // Decoded in the setup cycle, so paddr must be valid with psel
    always_comb begin
        rd_next = 16'h0000;
        if (sel_slow) begin
            rd_next = slow_xtal_reg;
        end else if (sel_fast) begin
            rd_next = fast_clk_reg;
        end else if (sel_lowf) begin
            rd_next = lowf_rc_reg;
        end else if (sel_ref) begin
            rd_next = ref_trim_reg;
        end else if (sel_stat) begin
            rd_next = ana_status_sync;
        end else if (sel_istat) begin
            rd_next = {14'h0000, irq_stat_reg};
        end else if (sel_ien) begin
            rd_next = {14'h0000, irq_en_reg};
        end
    end

    // Ready for exactly the one access cycle after setup
    // No wait states: every access ends in its first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= setup_phase;
        end
    end

    // Read data and error captured in the setup cycle
    // Cleared outside the access cycle so stale data never leaks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup_phase) begin
            prdata  <= pwrite ? 32'h0000_0000 : {16'h0000, rd_next};
            pslverr <= ~hit_any;
        end else begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
    end

    // ********************************************************************
    // Oscillator control registers
    // ********************************************************************

    // Slow crystal control, only the enable is stored
    // Its upper fields belong to other logic and read back as zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slow_xtal_reg <= SLOW_XTAL_RST;
        end else if (wr_en && sel_slow) begin
            slow_xtal_reg <= merge(slow_xtal_reg, SLOW_XTAL_WMSK,
                                   SLOW_XTAL_RST,
                                   lanes(slow_xtal_reg, wr_bits, pstrb[1:0]));
        end
    end

    // Fast clock control; bits 15 and 9:8 stay reserved
    // Bits 4:1 hold the fast RC trim; it resets to the lowest frequency
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast_clk_reg <= FAST_CLK_RST;
        end else if (wr_en && sel_fast) begin
            fast_clk_reg <= merge(fast_clk_reg, FAST_CLK_WMSK, FAST_CLK_RST,
                                  lanes(fast_clk_reg, wr_bits, pstrb[1:0]));
        end
    end

    // Low-frequency RC control; bits 15:12 reserved
    // Bias and temperature fields sit between range and trim
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lowf_rc_reg <= LOWF_RC_RST;
        end else if (wr_en && sel_lowf) begin
            lowf_rc_reg <= merge(lowf_rc_reg, LOWF_RC_WMSK, LOWF_RC_RST,
                                 lanes(lowf_rc_reg, wr_bits, pstrb[1:0]));
        end
    end

    // Reference and sleep regulator trims; bit 15 reserved
    // Select stays low until software moves the supplies to the reference
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_trim_reg <= REF_TRIM_RST;
        end else if (wr_en && sel_ref) begin
            ref_trim_reg <= merge(ref_trim_reg, REF_TRIM_WMSK, REF_TRIM_RST,
                                  lanes(ref_trim_reg, wr_bits, pstrb[1:0]));
        end
    end

    // ********************************************************************
    // Control outputs, straight from the register bits
    // ********************************************************************
    // Every control output is a plain register bit, free of glitches
    assign slow_crystal_osc_en = slow_xtal_reg[0];

    assign fast_clk_ctrl.crystal_highpass_en         = fast_clk_reg[14];
    assign fast_clk_ctrl.crystal_spike_filter_bypass = fast_clk_reg[13];
    assign fast_clk_ctrl.crystal_amplitude_trim      = fast_clk_reg[12:10];
    assign fast_clk_ctrl.crystal_startup_current     = fast_clk_reg[7:5];
    assign fast_clk_ctrl.fast_rc_osc_trim            = fast_clk_reg[4:1];
    assign fast_clk_ctrl.fast_rc_osc_en              = fast_clk_reg[0];

    assign lowfreq_rc_ctrl.lowfreq_rc_en        = lowf_rc_reg[11];
    assign lowfreq_rc_ctrl.lowfreq_rc_extra_low = lowf_rc_reg[10];
    assign lowfreq_rc_ctrl.lowfreq_rc_bias      = lowf_rc_reg[9:8];
    assign lowfreq_rc_ctrl.lowfreq_rc_temp_ctrl = lowf_rc_reg[7:4];
    assign lowfreq_rc_ctrl.lowfreq_rc_trim      = lowf_rc_reg[3:0];

    assign ref_trim_ctrl.supply_reg_ref_select  = ref_trim_reg[14];
    assign ref_trim_ctrl.sleep_reg_trim         = ref_trim_reg[13:10];
    assign ref_trim_ctrl.reference_bias_trim    = ref_trim_reg[9:5];
    assign ref_trim_ctrl.reference_voltage_trim = ref_trim_reg[4:0];

    // ********************************************************************
    // Analog status synchronisation
    // ********************************************************************

    // Status resets to its idle levels
    // Three flops plus agreement: a level shows four edges late
    level_sync #(
        .WIDTH     (16),
        .RESET_VAL (ANA_STAT_RST)
    ) u_status_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (ana_status_raw),
        .sync_out (ana_status_sync)
    );

    // ********************************************************************
    // USB supply interrupt
    // ********************************************************************

    // Previous comparator level for edge detection
    // Edges come from the filtered level, so a glitch raises nothing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vbus_prev_reg <= ANA_STAT_RST[VBUS_CMP_BIT];
        end else begin
            vbus_prev_reg <= ana_status_sync[VBUS_CMP_BIT];
        end
    end

    // One-cycle pulses on either edge of the supply comparator
    assign vbus_rise = ana_status_sync[VBUS_CMP_BIT] & ~vbus_prev_reg;
    assign vbus_fall = ~ana_status_sync[VBUS_CMP_BIT] & vbus_prev_reg;

    // Interrupt enables
    // Only the low byte holds the two enables; other lanes are ignored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en_reg <= IRQ_RST;
        end else if (wr_en && sel_ien && pstrb[0]) begin
            irq_en_reg <= pwdata[1:0];
        end
    end

    // Sticky status: clears first, new events win over them
    // Events set status whatever the enables; masking gates only the line
    always_comb begin
        irq_stat_next = irq_stat_reg;
        if (wr_en && sel_istat && pstrb[0]) begin
            irq_stat_next = irq_stat_reg & ~pwdata[1:0];
        end
        if (wr_en && sel_iclr) begin
            irq_stat_next = 2'b00;
        end
        irq_stat_next[IRQ_RISE_BIT] = irq_stat_next[IRQ_RISE_BIT] | vbus_rise;
        irq_stat_next[IRQ_FALL_BIT] = irq_stat_next[IRQ_FALL_BIT] | vbus_fall;
    end

    // Sticky status register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_reg <= IRQ_RST;
        end else begin
            irq_stat_reg <= irq_stat_next;
        end
    end

    // Level interrupt from unmasked sticky bits
    // Enable changes reach the line one edge after they are written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            usb_supply_irq <= 1'b0;
        end else begin
            usb_supply_irq <= |(irq_stat_next & irq_en_reg);
        end
    end

endmodule
`default_nettype wire
